// *** rtl/mwal_regs.svh ***
// Register indices, field positions and reset values of the monitor warning and alert logic
`ifndef MWAL_REGS_SVH
`define MWAL_REGS_SVH

// Register indices; byte address is four times the index
`define MWAL_IDX_OPERATION 8'h01
`define MWAL_IDX_CLEAR 8'h03
`define MWAL_IDX_OUTPUT_VOLTAGE_PIN_OV 8'h42
`define MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV 8'h43
`define MWAL_IDX_IOUT_OC 8'h4A
`define MWAL_IDX_VIN_OV 8'h57
`define MWAL_IDX_VIN_UV 8'h58
`define MWAL_IDX_STATUS 8'h79
`define MWAL_IDX_PMON_CTRL 8'hD3
`define MWAL_IDX_MASK1 8'hD5
`define MWAL_IDX_MASK2 8'hD6
`define MWAL_IDX_IOUT_W2 8'hD7
`define MWAL_IDX_DEV_CFG 8'hD8
`define MWAL_IDX_OWN_ADDR 8'hE0
`define MWAL_IDX_ALERT_STATE 8'hE1

// Reset values
`define MWAL_THR_MIN 12'h000
`define MWAL_THR_MAX 12'hFFF
`define MWAL_MASK1_RST 16'h0000
`define MWAL_MASK2_RST 16'h0800
`define MWAL_OWN_ADDR_RST 7'h10

// Status bit positions
`define MWAL_ST_CML 0
`define MWAL_ST_REGULATION_ACTIVE_WARNING 1
`define MWAL_ST_OC_WARN 2
`define MWAL_ST_W2_WARN 3
`define MWAL_ST_VIN_UV 4
`define MWAL_ST_VIN_OV 5
`define MWAL_ST_OUTPUT_VOLTAGE_PIN_UV 6
`define MWAL_ST_OUTPUT_VOLTAGE_PIN_OV 7
`define MWAL_ST_UV_FAULT 8
`define MWAL_ST_OV_FAULT 9
`define MWAL_ST_OC_FAULT 10
`define MWAL_ST_FET_BAD 11
`define MWAL_ST_W 12

// Mask register control fields, operation on bit and device config bit
`define MWAL_MASK_GPO_MODE 15
`define MWAL_MASK_GPO_LEVEL 14
`define MWAL_MASK_INVERT 13
`define MWAL_OPER_ON 7
`define MWAL_CFG_W2_UNDER 0

// Alert response read: address 0x0C with read bit
`define MWAL_ARA_READ 8'h19

`endif

// *** rtl/mwal_pkg.sv ***
// Types of the monitor warning and alert logic
package mwal_pkg;
  typedef enum logic [2:0] {
    MWAL_SMB_IDLE,
    MWAL_SMB_ADDR,
    MWAL_SMB_ADDR_ACK,
    MWAL_SMB_TX,
    MWAL_SMB_TX_ACK
  } mwal_smb_state_t;
endpackage : mwal_pkg

// *** rtl/mwal_top.sv ***
// Monitor warning comparators, status latches, alert pins and alert response slave
`timescale 1ns/100ps
`include "mwal_regs.svh"
module mwal_top import mwal_pkg::*; (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [11:0] vin_sample_i,
  input wire logic vin_valid_i,
  input wire logic [11:0] output_voltage_pin_sample_i,
  input wire logic output_voltage_pin_valid_i,
  input wire logic [11:0] iout_sample_i,
  input wire logic iout_valid_i,
  input wire logic uv_pin_fault_i,
  input wire logic ov_pin_fault_i,
  input wire logic oc_timeout_fault_i,
  input wire logic regulation_active_i,
  input wire logic fet_health_bad_i,
  output logic hotswap_enable_o,
  input wire logic first_alert_output_i,
  output logic first_alert_output_o,
  output logic first_alert_output_oe_o,
  input wire logic second_alert_output_i,
  output logic second_alert_output_o,
  output logic second_alert_output_oe_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);

  // Configuration registers
  logic [11:0] input_overvoltage_threshold;
  logic [11:0] input_undervoltage_threshold;
  logic [11:0] output_overvoltage_threshold;
  logic [11:0] output_undervoltage_threshold;
  logic [11:0] overcurrent_threshold;
  logic [11:0] second_current_threshold;
  logic [15:0] first_alert_mask;
  logic [15:0] second_alert_mask;
  logic [7:0] pmon_control;
  logic [7:0] device_config;
  logic [6:0] own_address;
  logic oper_on;
  logic oper_on_d;

  // Status and alert state
  logic [`MWAL_ST_W-1:0] status;
  logic [`MWAL_ST_W-1:0] next_status;
  logic [`MWAL_ST_W-1:0] cond;
  logic [`MWAL_ST_W-1:0] new_set;
  logic alert1_pend;
  logic alert2_pend;
  logic fault_off;

  // Bus handshake state
  logic wr_pend;
  logic [7:0] wr_idx;
  logic acc;
  logic [7:0] a_idx;
  logic clear_wr;
  logic off_on;

  // Synchronisers for pins from outside the clock domain
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic scl_d;
  logic sda_d;
  logic uv_f;
  logic ov_f;
  logic oc_f;
  logic reg_act;
  logic fet_bad;
  logic scl_s;
  logic sda_s;

  // Alert response slave
  mwal_smb_state_t smb_state;
  logic [3:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic ara_win;
  logic smb_err;
  logic scl_rise;
  logic scl_fall;
  logic smb_start;
  logic smb_stop;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Idle pin levels: bus lines high, fault and status pins low, so reset makes no false event
      pin_s1 <= 7'h60;
      pin_s2 <= 7'h60;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      pin_s1 <= {scl_i, sda_i, fet_health_bad_i, regulation_active_i, oc_timeout_fault_i, ov_pin_fault_i,
                 uv_pin_fault_i};
      pin_s2 <= pin_s1;
      scl_d <= pin_s2[6];
      sda_d <= pin_s2[5];
    end
  end

  assign uv_f = pin_s2[0];
  assign ov_f = pin_s2[1];
  assign oc_f = pin_s2[2];
  assign reg_act = pin_s2[3];
  assign fet_bad = pin_s2[4];
  assign sda_s = pin_s2[5];
  assign scl_s = pin_s2[6];
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign smb_start = scl_s & scl_d & sda_d & ~sda_s;
  assign smb_stop = scl_s & scl_d & ~sda_d & sda_s;

  // AHB-Lite slave: zero wait states, always OKAY
  assign acc = hsel_i & htrans_i[1] & hready_i;
  assign a_idx = haddr_i[9:2];
  assign clear_wr = wr_pend & (wr_idx == `MWAL_IDX_CLEAR);
  assign off_on = oper_on & ~oper_on_d;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend <= acc & hwrite_i;
      wr_idx <= a_idx;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (acc & ~hwrite_i) begin
      case (a_idx)
        `MWAL_IDX_OPERATION: hrdata_o <= {24'h00_0000, oper_on, 7'h00};
        `MWAL_IDX_OUTPUT_VOLTAGE_PIN_OV: hrdata_o <= {20'h0_0000, output_overvoltage_threshold};
        `MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV: hrdata_o <= {20'h0_0000, output_undervoltage_threshold};
        `MWAL_IDX_IOUT_OC: hrdata_o <= {20'h0_0000, overcurrent_threshold};
        `MWAL_IDX_VIN_OV: hrdata_o <= {20'h0_0000, input_overvoltage_threshold};
        `MWAL_IDX_VIN_UV: hrdata_o <= {20'h0_0000, input_undervoltage_threshold};
        `MWAL_IDX_STATUS: hrdata_o <= {20'h0_0000, status};
        `MWAL_IDX_PMON_CTRL: hrdata_o <= {24'h00_0000, pmon_control};
        `MWAL_IDX_MASK1: hrdata_o <= {16'h0000, first_alert_mask};
        `MWAL_IDX_MASK2: hrdata_o <= {16'h0000, second_alert_mask};
        `MWAL_IDX_IOUT_W2: hrdata_o <= {20'h0_0000, second_current_threshold};
        `MWAL_IDX_DEV_CFG: hrdata_o <= {24'h00_0000, device_config};
        `MWAL_IDX_OWN_ADDR: hrdata_o <= {25'h000_0000, own_address};
        `MWAL_IDX_ALERT_STATE: hrdata_o <= {28'h000_0000, fault_off, oper_on, alert2_pend, alert1_pend};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end else begin
      hrdata_o <= 32'h0000_0000;
    end
  end

  // Thresholds reset so that no warning but the second current warning (threshold 0, over mode) can fire before programming
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      input_overvoltage_threshold <= `MWAL_THR_MAX;
      input_undervoltage_threshold <= `MWAL_THR_MIN;
      output_overvoltage_threshold <= `MWAL_THR_MAX;
      output_undervoltage_threshold <= `MWAL_THR_MIN;
      overcurrent_threshold <= `MWAL_THR_MAX;
      second_current_threshold <= `MWAL_THR_MIN;
      first_alert_mask <= `MWAL_MASK1_RST;
      second_alert_mask <= `MWAL_MASK2_RST;
      pmon_control <= 8'h00;
      device_config <= 8'h00;
      own_address <= `MWAL_OWN_ADDR_RST;
      oper_on <= 1'b1;
    end else if (wr_pend) begin
      case (wr_idx)
        `MWAL_IDX_OPERATION: oper_on <= hwdata_i[`MWAL_OPER_ON];
        `MWAL_IDX_OUTPUT_VOLTAGE_PIN_OV: output_overvoltage_threshold <= hwdata_i[11:0];
        `MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV: output_undervoltage_threshold <= hwdata_i[11:0];
        `MWAL_IDX_IOUT_OC: overcurrent_threshold <= hwdata_i[11:0];
        `MWAL_IDX_VIN_OV: input_overvoltage_threshold <= hwdata_i[11:0];
        `MWAL_IDX_VIN_UV: input_undervoltage_threshold <= hwdata_i[11:0];
        `MWAL_IDX_PMON_CTRL: pmon_control <= hwdata_i[7:0];
        `MWAL_IDX_MASK1: first_alert_mask <= hwdata_i[15:0];
        `MWAL_IDX_MASK2: second_alert_mask <= hwdata_i[15:0];
        `MWAL_IDX_IOUT_W2: second_current_threshold <= hwdata_i[11:0];
        `MWAL_IDX_DEV_CFG: device_config <= hwdata_i[7:0];
        `MWAL_IDX_OWN_ADDR: own_address <= hwdata_i[6:0];
        default: oper_on <= oper_on;
      endcase
    end
  end

  // Warning conditions: samples strike once per conversion, faults and regulation are levels
  always_comb begin
    cond = '0;
    cond[`MWAL_ST_CML] = smb_err;
    cond[`MWAL_ST_REGULATION_ACTIVE_WARNING] = reg_act;
    cond[`MWAL_ST_OC_WARN] = iout_valid_i & (iout_sample_i > overcurrent_threshold);
    if (device_config[`MWAL_CFG_W2_UNDER]) begin
      cond[`MWAL_ST_W2_WARN] = iout_valid_i & (iout_sample_i < second_current_threshold);
    end else begin
      cond[`MWAL_ST_W2_WARN] = iout_valid_i & (iout_sample_i > second_current_threshold);
    end
    cond[`MWAL_ST_VIN_UV] = vin_valid_i & (vin_sample_i < input_undervoltage_threshold);
    cond[`MWAL_ST_VIN_OV] = vin_valid_i & (vin_sample_i > input_overvoltage_threshold);
    cond[`MWAL_ST_OUTPUT_VOLTAGE_PIN_UV] = output_voltage_pin_valid_i & (output_voltage_pin_sample_i < output_undervoltage_threshold);
    cond[`MWAL_ST_OUTPUT_VOLTAGE_PIN_OV] = output_voltage_pin_valid_i & (output_voltage_pin_sample_i > output_overvoltage_threshold);
    cond[`MWAL_ST_UV_FAULT] = uv_f;
    cond[`MWAL_ST_OV_FAULT] = ov_f;
    cond[`MWAL_ST_OC_FAULT] = oc_f;
    cond[`MWAL_ST_FET_BAD] = fet_bad;
  end

  // Latched status: a live condition wins over a clear in the same cycle
  always_comb begin
    if (clear_wr | off_on) begin
      next_status = cond;
    end else begin
      next_status = status | cond;
    end
  end

  assign new_set = next_status & ~status;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  // Hot-swap output: faults switch it off until an off-then-on sequence
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      oper_on_d <= 1'b1;
      fault_off <= 1'b0;
      hotswap_enable_o <= 1'b0;
    end else begin
      oper_on_d <= oper_on;
      if (uv_f | ov_f | oc_f) begin
        fault_off <= 1'b1;
      end else if (off_on) begin
        fault_off <= 1'b0;
      end
      hotswap_enable_o <= oper_on & ~fault_off & ~(uv_f | ov_f | oc_f);
    end
  end

  // Alerts set on newly set enabled bits, released together
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alert1_pend <= 1'b0;
      alert2_pend <= 1'b0;
    end else begin
      if (|(new_set & first_alert_mask[`MWAL_ST_W-1:0])) begin
        alert1_pend <= 1'b1;
      end else if (clear_wr | ara_win) begin
        alert1_pend <= 1'b0;
      end
      if (|(new_set & second_alert_mask[`MWAL_ST_W-1:0])) begin
        alert2_pend <= 1'b1;
      end else if (clear_wr | ara_win) begin
        alert2_pend <= 1'b0;
      end
    end
  end

  // Open-drain alert pins: enable pulls low; GPO mode bypasses the masks
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      first_alert_output_o <= 1'b0;
      first_alert_output_oe_o <= 1'b0;
      second_alert_output_o <= 1'b0;
      second_alert_output_oe_o <= 1'b0;
    end else begin
      first_alert_output_o <= 1'b0;
      second_alert_output_o <= 1'b0;
      if (first_alert_mask[`MWAL_MASK_GPO_MODE]) begin
        first_alert_output_oe_o <= ~first_alert_mask[`MWAL_MASK_GPO_LEVEL];
      end else begin
        first_alert_output_oe_o <= alert1_pend ^ first_alert_mask[`MWAL_MASK_INVERT];
      end
      if (second_alert_mask[`MWAL_MASK_GPO_MODE]) begin
        second_alert_output_oe_o <= ~second_alert_mask[`MWAL_MASK_GPO_LEVEL];
      end else begin
        second_alert_output_oe_o <= alert2_pend ^ second_alert_mask[`MWAL_MASK_INVERT];
      end
    end
  end

  // Alert response slave: answers only the receive-byte at the response address
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smb_state <= MWAL_SMB_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      ara_win <= 1'b0;
      smb_err <= 1'b0;
    end else begin
      ara_win <= 1'b0;
      smb_err <= 1'b0;
      sda_o <= 1'b0;
      if (smb_start | smb_stop) begin
        if (((smb_state == MWAL_SMB_ADDR) | (smb_state == MWAL_SMB_TX)) & (bit_cnt != 4'h0)) begin
          smb_err <= 1'b1;
        end
        smb_state <= smb_start ? MWAL_SMB_ADDR : MWAL_SMB_IDLE;
        bit_cnt <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (smb_state)
          MWAL_SMB_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          MWAL_SMB_ADDR: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall & (bit_cnt == 4'h8)) begin
              if ((rx_shift == `MWAL_ARA_READ) & (alert1_pend | alert2_pend)) begin
                sda_oe_o <= 1'b1;
                smb_state <= MWAL_SMB_ADDR_ACK;
              end else begin
                smb_state <= MWAL_SMB_IDLE;
              end
            end
          end
          MWAL_SMB_ADDR_ACK: begin
            if (scl_fall) begin
              tx_shift <= {own_address, 1'b1};
              sda_oe_o <= ~own_address[6];
              bit_cnt <= 4'h0;
              smb_state <= MWAL_SMB_TX;
            end
          end
          MWAL_SMB_TX: begin
            if (scl_rise) begin
              if (tx_shift[7] & ~sda_s) begin
                sda_oe_o <= 1'b0;
                smb_state <= MWAL_SMB_IDLE;
              end else begin
                tx_shift <= {tx_shift[6:0], 1'b1};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end else if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_o <= 1'b0;
                ara_win <= 1'b1;
                smb_state <= MWAL_SMB_TX_ACK;
              end else begin
                sda_oe_o <= ~tx_shift[7];
              end
            end
          end
          MWAL_SMB_TX_ACK: begin
            if (scl_fall) begin
              smb_state <= MWAL_SMB_IDLE;
            end
          end
          default: begin
            smb_state <= MWAL_SMB_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : mwal_top

// *** testbench/mwal_top_sva.sv ***
// Port-level assertions for the monitor warning and alert logic
`timescale 1ns/100ps
module mwal_top_chk (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic uv_pin_fault_i,
  input wire logic ov_pin_fault_i,
  input wire logic oc_timeout_fault_i,
  input wire logic hotswap_enable_o,
  input wire logic first_alert_output_o,
  input wire logic first_alert_output_oe_o,
  input wire logic second_alert_output_o,
  input wire logic second_alert_output_oe_o,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic flt;
  logic [3:0] cause;
  assign flt = uv_pin_fault_i | ov_pin_fault_i | oc_timeout_fault_i;
  // Recent faults or register writes that may legally switch the output off
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cause <= 4'h0;
    end else begin
      cause <= {cause[2:0], flt | (hsel_i && htrans_i[1] && hwrite_i && hready_i)};
    end
  end
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("wait state or error response");
  a_rdata_idle: assert property (!(hsel_i && htrans_i[1] && !hwrite_i && hready_i) |=> hrdata_o == 32'h0)
    else $error("read data outside read data phase");
  a_alert_drain: assert property (!first_alert_output_o && !second_alert_output_o)
    else $error("alert pin driven high");
  a_sda_drain: assert property (!sda_o)
    else $error("data line driven high");
  a_fault_off: assert property (flt [*3] |=> !hotswap_enable_o)
    else $error("fault left hot-swap on");
  a_warn_keep: assert property ($fell(hotswap_enable_o) |-> |cause)
    else $error("hot-swap off without fault or write");
  a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved while clock high");
  a_reset_free: assert property ($fell(sys_rst_i) |-> !first_alert_output_oe_o && !second_alert_output_oe_o)
    else $error("alert pulled after reset");
endmodule : mwal_top_chk

bind mwal_top mwal_top_chk u_chk (.core_clk_i, .sys_rst_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .uv_pin_fault_i, .ov_pin_fault_i, .oc_timeout_fault_i, .hotswap_enable_o,
  .first_alert_output_o, .first_alert_output_oe_o, .second_alert_output_o, .second_alert_output_oe_o,
  .scl_i, .sda_o, .sda_oe_o);

// *** testbench/mwal_smb_host.sv ***
// SMBus host model that issues alert response reads
`timescale 1ns/100ps
`include "mwal_regs.svh"
module mwal_smb_host (
  input wire logic core_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : wt
  // One 160 ns clock; data moves only while the clock is low
  task automatic bit_io(input logic drv, output logic smp);
    wt(2);
    sda_low_o <= !drv;
    wt(6);
    scl_o <= 1'b1;
    wt(8);
    smp = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io
  // Receive byte at the response address; comp plays a rival responder, abort stops mid-byte
  task automatic ara_read(input logic [7:0] comp, input logic abort, output logic [7:0] rx, output logic ack);
    logic [7:0] a;
    logic b;
    a = `MWAL_ARA_READ;
    rx = 8'h00;
    ack = 1'b1;
    sda_low_o <= 1'b1;
    wt(8);
    scl_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!abort || i > 3) bit_io(a[i], b);
    end
    if (!abort) begin
      bit_io(1'b1, ack);
      for (int i = 7; i >= 0; i--) bit_io(comp[i], rx[i]);
      bit_io(1'b1, b);
    end
    wt(2);
    sda_low_o <= 1'b1;
    wt(6);
    scl_o <= 1'b1;
    wt(8);
    sda_low_o <= 1'b0;
    wt(8);
  endtask : ara_read
endmodule : mwal_smb_host

// *** testbench/tb_mwal_top.sv ***
// Self-checking bench for the monitor warning and alert logic
`timescale 1ns/100ps
`include "mwal_regs.svh"
module tb_mwal_top;
  typedef struct packed {logic [7:0] idx; logic [1:0] ch; logic ovr; logic [3:0] bt;} mwal_case_t;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_pend = 1'b0, reg_act = 1'b0, fet_bad = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [11:0] vs [3] = '{12'h000, 12'h000, 12'h000};
  logic [2:0] vld = 3'b000, flt = 3'b000;
  wire [31:0] hrdata;
  wire hrdy, hresp, hs_en, a1_oe, a2_oe, scl, sda_oe, sda_low;
  wire sda = !(sda_oe | sda_low);
  int n_errors = 0, n_tests = 0;
  logic [31:0] exp_q [$];
  logic [39:0] rv [13] = '{{`MWAL_IDX_VIN_OV, 32'h0000_0FFF}, {`MWAL_IDX_VIN_UV, 32'h0},
    {`MWAL_IDX_OUTPUT_VOLTAGE_PIN_OV, 32'h0000_0FFF}, {`MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV, 32'h0}, {`MWAL_IDX_IOUT_OC, 32'h0000_0FFF},
    {`MWAL_IDX_IOUT_W2, 32'h0}, {`MWAL_IDX_MASK1, 32'h0}, {`MWAL_IDX_MASK2, 32'h0000_0800},
    {`MWAL_IDX_STATUS, 32'h0}, {8'h20, 32'h0}, {`MWAL_IDX_OWN_ADDR, 32'h10}, {`MWAL_IDX_OPERATION, 32'h80},
    {`MWAL_IDX_ALERT_STATE, 32'h4}};
  mwal_case_t cs [7] = '{'{`MWAL_IDX_VIN_OV, 2'd0, 1'b1, 4'd5}, '{`MWAL_IDX_VIN_UV, 2'd0, 1'b0, 4'd4},
    '{`MWAL_IDX_OUTPUT_VOLTAGE_PIN_OV, 2'd1, 1'b1, 4'd7}, '{`MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV, 2'd1, 1'b0, 4'd6},
    '{`MWAL_IDX_IOUT_OC, 2'd2, 1'b1, 4'd2}, '{`MWAL_IDX_IOUT_W2, 2'd2, 1'b1, 4'd3},
    '{`MWAL_IDX_IOUT_W2, 2'd2, 1'b0, 4'd3}};
  always #5 clk = ~clk;
  mwal_top dut (.core_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .vin_sample_i(vs[0]), .vin_valid_i(vld[0]), .output_voltage_pin_sample_i(vs[1]),
    .output_voltage_pin_valid_i(vld[1]), .iout_sample_i(vs[2]), .iout_valid_i(vld[2]), .uv_pin_fault_i(flt[0]),
    .ov_pin_fault_i(flt[1]), .oc_timeout_fault_i(flt[2]), .regulation_active_i(reg_act),
    .fet_health_bad_i(fet_bad), .hotswap_enable_o(hs_en), .first_alert_output_i(!a1_oe),
    .first_alert_output_o(), .first_alert_output_oe_o(a1_oe), .second_alert_output_i(!a2_oe),
    .second_alert_output_o(), .second_alert_output_oe_o(a2_oe), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe_o(sda_oe));
  mwal_smb_host host (.core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : cmp_data
  task automatic cmp_line(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t pins %h expected %h", $time, got, exp);
    end
  endtask : cmp_line
  // Read results are checked in their data phase, oldest note first
  always @(posedge clk) begin
    if (rd_pend) cmp_data(hrdata, exp_q.pop_front());
    rd_pend <= hsel && htrans[1] && !hwrite && hrdy;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_errors++;
      stop_test();
    end
  endtask : rdy
  task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    if (!w) exp_q.push_back(d);
    rdy();
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0;
    rdy();
  endtask : acc
  task automatic smp(input int c, input logic [11:0] v);
    vs[c] <= v;
    vld[c] <= 1'b1;
    @(posedge clk);
    vld[c] <= 1'b0;
    wt(3);
  endtask : smp
  initial begin
    logic [7:0] rx;
    logic ack;
    logic [11:0] t;
    void'($urandom(40615));
    wt(6);
    rst <= 1'b0;
    hsel <= 1'b1;
    wt(2);
    cmp_line({hs_en, a1_oe, a2_oe}, 3'b100);
    foreach (rv[i]) acc(1'b0, rv[i][39:32], rv[i][31:0]);
    acc(1'b1, `MWAL_IDX_IOUT_W2, 32'h0000_0FFF);
    for (int i = 0; i < 24; i++) smp(i % 3, i < 3 ? 12'hFFF : i < 6 ? 12'h000 : 12'($urandom));
    acc(1'b0, `MWAL_IDX_STATUS, 32'h0);
    foreach (cs[i]) begin
      t = 12'($urandom_range(12'hFFE, 12'h001));
      if (i == 6) acc(1'b1, `MWAL_IDX_DEV_CFG, 32'h1);
      acc(1'b1, cs[i].idx, {20'h0, t});
      smp(cs[i].ch, t);
      acc(1'b0, `MWAL_IDX_STATUS, 32'h0);
      smp(cs[i].ch, cs[i].ovr ? t + 12'h001 : t - 12'h001);
      smp(cs[i].ch, t);
      acc(1'b0, `MWAL_IDX_STATUS, 32'h1 << cs[i].bt);
      acc(1'b1, `MWAL_IDX_CLEAR, 32'h0);
      acc(1'b0, `MWAL_IDX_STATUS, 32'h0);
      acc(1'b1, cs[i].idx, cs[i].ovr ? 32'h0000_0FFF : 32'h0);
    end
    acc(1'b1, `MWAL_IDX_MASK1, 32'h0000_2040);
    wt(3);
    cmp_line(a1_oe, 1);
    acc(1'b1, `MWAL_IDX_MASK1, 32'h0000_0040);
    fet_bad <= 1'b1;
    wt(8);
    cmp_line({a1_oe, a2_oe}, 2'b01);
    acc(1'b1, `MWAL_IDX_OUTPUT_VOLTAGE_PIN_UV, 32'h0000_0800);
    smp(1, 12'h7FF);
    cmp_line({a1_oe, a2_oe}, 2'b11);
    acc(1'b1, `MWAL_IDX_CLEAR, 32'h0);
    wt(6);
    cmp_line({a1_oe, a2_oe}, 2'b00);
    acc(1'b0, `MWAL_IDX_STATUS, 32'h0000_0800);
    smp(1, 12'h7FF);
    cmp_line({a1_oe, a2_oe}, 2'b10);
    host.ara_read(8'h11, 1'b0, rx, ack);
    cmp_line({ack, rx}, {1'b0, 8'h11});
    cmp_line(a1_oe, 1);
    host.ara_read(8'hFF, 1'b0, rx, ack);
    cmp_line({ack, rx}, {1'b0, `MWAL_OWN_ADDR_RST, 1'b1});
    cmp_line({a1_oe, a2_oe}, 2'b00);
    host.ara_read(8'hFF, 1'b0, rx, ack);
    cmp_line(ack, 1);
    fet_bad <= 1'b0;
    acc(1'b1, `MWAL_IDX_MASK2, 32'h0000_8000);
    wt(3);
    cmp_line(a2_oe, 1);
    acc(1'b1, `MWAL_IDX_MASK2, 32'h0000_0800);
    host.ara_read(8'hFF, 1'b1, rx, ack);
    acc(1'b0, `MWAL_IDX_STATUS, 32'h0000_0841);
    acc(1'b1, `MWAL_IDX_CLEAR, 32'h0);
    reg_act <= 1'b1;
    wt(6);
    reg_act <= 1'b0;
    acc(1'b0, `MWAL_IDX_STATUS, 32'h2);
    cmp_line(hs_en, 1);
    wt(4);
    for (int i = 0; i < 3; i++) begin
      flt <= 3'b001 << i;
      wt(6);
      cmp_line(hs_en, 0);
      acc(1'b0, `MWAL_IDX_ALERT_STATE, 32'hC);
      acc(1'b1, `MWAL_IDX_CLEAR, 32'h0);
      acc(1'b0, `MWAL_IDX_STATUS, 32'h100 << i);
      flt <= 3'b000;
      wt(4);
      acc(1'b1, `MWAL_IDX_CLEAR, 32'h0);
      acc(1'b0, `MWAL_IDX_STATUS, 32'h0);
      acc(1'b1, `MWAL_IDX_OPERATION, 32'h0);
      acc(1'b1, `MWAL_IDX_OPERATION, 32'h80);
      wt(4);
      cmp_line(hs_en, 1);
    end
    stop_test();
  end
endmodule : tb_mwal_top
